/* rtl/sfl_pkg.sv */
// Package for the status flag logic: offsets, field positions, types
package sfl_pkg;

   // Register indices; each word sits at four times its index
   localparam logic [11:0] STATUS_INDEX = 12'h0d0;
   localparam logic [11:0] POWER_INDEX  = 12'h087;

   // Register word byte addresses on the APB
   localparam logic [11:0] ADDR_STATUS = {STATUS_INDEX[9:0], 2'b00};
   localparam logic [11:0] ADDR_POWER  = {POWER_INDEX[9:0], 2'b00};
   localparam logic [11:0] ADDR_ACC    = 12'h008;

   // Status word field positions
   localparam int STAT_CARRY  = 7;
   localparam int STAT_AUX    = 6;
   localparam int STAT_USER0  = 5;
   localparam int STAT_BANK1  = 4;
   localparam int STAT_BANK0  = 3;
   localparam int STAT_OVF    = 2;
   localparam int STAT_USER1  = 1;
   localparam int STAT_PARITY = 0;

   // Power control field positions kept here
   localparam int POWER_GEN1 = 3;
   localparam int POWER_GEN0 = 2;

   // Reset values and power control write mask
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] POWER_RESET  = 8'h00;
   localparam logic [7:0] POWER_MASK   = 8'h0c;

   // Multiply overflow limit
   localparam logic [15:0] MUL_LIMIT = 16'h00ff;

   // Instruction classes seen by the flag logic
   typedef enum logic [4:0] {
      SFL_OP_NONE,
      SFL_OP_ADD,
      SFL_OP_ADDC,
      SFL_OP_SUBB,
      SFL_OP_MUL,
      SFL_OP_DIV,
      SFL_OP_DA,
      SFL_OP_RRC,
      SFL_OP_RLC,
      SFL_OP_SETB_C,
      SFL_OP_CLR_C,
      SFL_OP_CPL_C,
      SFL_OP_ANL_C,
      SFL_OP_ANL_NC,
      SFL_OP_ORL_C,
      SFL_OP_ORL_NC,
      SFL_OP_MOV_C,
      SFL_OP_CJNE
   } sfl_op_t;

   // One instruction from the decoder
   typedef struct packed {
      logic       valid;
      sfl_op_t    op;
      logic [7:0] opa;
      logic [7:0] opb;
      logic       bit_in;
      logic       da_carry;
   } sfl_req_t;

   // Flag results
   typedef struct packed {
      logic wr_carry;
      logic carry;
      logic wr_ovf;
      logic ovf;
      logic wr_aux;
      logic aux;
   } sfl_flags_t;

endpackage

/* rtl/sfl_flag_calc.sv */
// Combinational flag computation for one instruction
`timescale 1ns/1ps
module sfl_flag_calc (
   // Instruction and current carry
   input  wire sfl_pkg::sfl_req_t   req,
   input  wire logic                carry_in,
   // Flag updates
   output      sfl_pkg::sfl_flags_t flags
);

   logic [8:0]  sum9;
   logic [7:0]  sum7;
   logic [4:0]  sum4;
   logic [15:0] prod;
   logic        cin;

   always_comb begin
      flags = '0;
      cin   = (req.op == sfl_pkg::SFL_OP_ADDC ||
               req.op == sfl_pkg::SFL_OP_SUBB) ? carry_in : 1'b0;
      sum9  = 9'h000;
      sum7  = 8'h00;
      sum4  = 5'h00;
      prod  = 16'(req.opa) * 16'(req.opb);
      if (req.op == sfl_pkg::SFL_OP_SUBB) begin
         // Borrow chain: a - b - cin, bit 8 is borrow out of bit 7
         sum9 = {1'b0, req.opa} - {1'b0, req.opb} - {8'h00, cin};
         sum7 = {1'b0, req.opa[6:0]} - {1'b0, req.opb[6:0]} - {7'h00, cin};
         sum4 = {1'b0, req.opa[3:0]} - {1'b0, req.opb[3:0]} - {4'h0, cin};
      end else begin
         sum9 = {1'b0, req.opa} + {1'b0, req.opb} + {8'h00, cin};
         sum7 = {1'b0, req.opa[6:0]} + {1'b0, req.opb[6:0]} + {7'h00, cin};
         sum4 = {1'b0, req.opa[3:0]} + {1'b0, req.opb[3:0]} + {4'h0, cin};
      end
      unique case (req.op)
         sfl_pkg::SFL_OP_ADD, sfl_pkg::SFL_OP_ADDC,
         sfl_pkg::SFL_OP_SUBB: begin
            flags.wr_carry = 1'b1;
            flags.carry    = sum9[8];
            flags.wr_ovf   = 1'b1;
            flags.ovf      = sum9[8] ^ sum7[7];
            flags.wr_aux   = 1'b1;
            flags.aux      = sum4[4];
         end
         sfl_pkg::SFL_OP_MUL: begin
            flags.wr_carry = 1'b1;
            flags.wr_ovf   = 1'b1;
            flags.ovf      = prod > sfl_pkg::MUL_LIMIT;
         end
         sfl_pkg::SFL_OP_DIV: begin
            flags.wr_carry = 1'b1;
            flags.wr_ovf   = 1'b1;
            flags.ovf      = (req.opb == 8'h00);
         end
         sfl_pkg::SFL_OP_DA: begin
            flags.wr_carry = 1'b1;
            flags.carry    = carry_in | req.da_carry;
         end
         sfl_pkg::SFL_OP_RRC: begin
            flags.wr_carry = 1'b1;
            flags.carry    = req.opa[0];
         end
         sfl_pkg::SFL_OP_RLC: begin
            flags.wr_carry = 1'b1;
            flags.carry    = req.opa[7];
         end
         sfl_pkg::SFL_OP_SETB_C: begin
            flags.wr_carry = 1'b1;
            flags.carry    = 1'b1;
         end
         sfl_pkg::SFL_OP_CLR_C: begin
            flags.wr_carry = 1'b1;
         end
         sfl_pkg::SFL_OP_CPL_C: begin
            flags.wr_carry = 1'b1;
            flags.carry    = ~carry_in;
         end
         sfl_pkg::SFL_OP_ANL_C: begin
            flags.wr_carry = 1'b1;
            flags.carry    = carry_in & req.bit_in;
         end
         sfl_pkg::SFL_OP_ANL_NC: begin
            flags.wr_carry = 1'b1;
            flags.carry    = carry_in & ~req.bit_in;
         end
         sfl_pkg::SFL_OP_ORL_C: begin
            flags.wr_carry = 1'b1;
            flags.carry    = carry_in | req.bit_in;
         end
         sfl_pkg::SFL_OP_ORL_NC: begin
            flags.wr_carry = 1'b1;
            flags.carry    = carry_in | ~req.bit_in;
         end
         sfl_pkg::SFL_OP_MOV_C: begin
            flags.wr_carry = 1'b1;
            flags.carry    = req.bit_in;
         end
         sfl_pkg::SFL_OP_CJNE: begin
            flags.wr_carry = 1'b1;
            flags.carry    = req.opa < req.opb;
         end
         sfl_pkg::SFL_OP_NONE: begin
            flags = '0;
         end
         default: begin
            flags = '0;
         end
      endcase
   end

endmodule

/* rtl/sfl_status_flags.sv */
// Program status word flag logic with APB register access
`timescale 1ns/1ps
module sfl_status_flags (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   // Core datapath
   input  wire sfl_pkg::sfl_req_t req,
   input  wire logic [7:0]        acc,
   // Flag outputs
   output      logic [7:0]        program_status_word,
   output      logic [7:0]        power_control,
   output      logic              parity_flag
);

   logic [7:0]          status_q;
   logic [7:0]          power_q;
   logic [31:0]         prdata_q;
   logic                pslverr_q;
   logic                parity;
   sfl_pkg::sfl_flags_t flags;
   logic                access;
   logic                wr_status;
   logic                wr_power;
   logic                mapped;

   function automatic logic odd_ones(input logic [7:0] v);
      return ^v;
   endfunction

   sfl_flag_calc u_calc (
      .req   (req),
      .carry_in (status_q[sfl_pkg::STAT_CARRY]),
      .flags    (flags)
   );

   assign parity  = odd_ones(acc);
   assign access  = psel & penable;
   assign mapped  = (paddr == sfl_pkg::ADDR_STATUS) ||
                    (paddr == sfl_pkg::ADDR_POWER) ||
                    (paddr == sfl_pkg::ADDR_ACC);
   assign wr_status = access & pwrite & pstrb[0] &
                      (paddr == sfl_pkg::ADDR_STATUS);
   assign wr_power  = access & pwrite & pstrb[0] &
                      (paddr == sfl_pkg::ADDR_POWER);

   // Zero wait states
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // Core update outranks a same-cycle software write to the same flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= sfl_pkg::STATUS_RESET;
      end else if (clk_en) begin
         if (wr_status) begin
            status_q[7:1] <= pwdata[7:1];
         end
         if (req.valid) begin
            if (flags.wr_carry) begin
               status_q[sfl_pkg::STAT_CARRY] <= flags.carry;
            end
            if (flags.wr_ovf) begin
               status_q[sfl_pkg::STAT_OVF] <= flags.ovf;
            end
            if (flags.wr_aux) begin
               status_q[sfl_pkg::STAT_AUX] <= flags.aux;
            end
         end
         status_q[sfl_pkg::STAT_PARITY] <= parity;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_q <= sfl_pkg::POWER_RESET;
      end else if (clk_en && wr_power) begin
         power_q <= pwdata[7:0] & sfl_pkg::POWER_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pslverr_q <= psel & ~penable & ~mapped;
         prdata_q  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               sfl_pkg::ADDR_STATUS: begin
                  prdata_q <= {24'h000000, status_q[7:1], parity};
               end
               sfl_pkg::ADDR_POWER: begin
                  prdata_q <= {24'h000000, power_q};
               end
               sfl_pkg::ADDR_ACC: begin
                  prdata_q <= {24'h000000, acc};
               end
               default: begin
                  prdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   assign program_status_word = {status_q[7:1], parity};
   assign power_control       = power_q;
   assign parity_flag         = parity;

endmodule

/* verification/sfl_flag_properties.sv */
// Port checker for the status flag logic
`timescale 1ns/1ps
module sfl_flag_checker (
   // Clock, reset, bus strobes
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              clk_en,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   // Core side and flags
   input wire sfl_pkg::sfl_req_t req,
   input wire logic [7:0]        acc,
   input wire logic [7:0]        program_status_word,
   input wire logic [7:0]        power_control,
   input wire logic              parity_flag
);
   logic [7:0] w;
   logic [8:0] s;
   logic       go, ad, sb, x7, x4;
   logic       e_ovf, e_carry, e_mul, e_div, e_cmp;
   assign w = program_status_word;
   assign go = req.valid && clk_en;
   assign sb = go && req.op == sfl_pkg::SFL_OP_SUBB;
   assign ad = go && req.op inside {sfl_pkg::SFL_OP_ADD, sfl_pkg::SFL_OP_ADDC};
   // Sum bit xor operand bits recovers the carry or borrow into that bit
   assign s = sb ? req.opa - req.opb - w[7]
                 : req.opa + req.opb + (req.op != sfl_pkg::SFL_OP_ADD && w[7]);
   assign x7 = s[7] ^ req.opa[7] ^ req.opb[7];
   assign x4 = s[4] ^ req.opa[4] ^ req.opb[4];
   assign e_ovf   = s[8] ^ x7;
   assign e_carry = s[8];
   assign e_mul   = ({8'h00, req.opa} * {8'h00, req.opb}) > sfl_pkg::MUL_LIMIT;
   assign e_div   = req.opb == 8'h00;
   assign e_cmp   = req.opa < req.opb;
   default clocking
      @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_add_ovf: assert property (
      ad |=> w[2] == $past(e_ovf)) else $error("add overflow wrong");
   chk_sub_ovf: assert property (
      sb |=> w[2] == $past(e_ovf)) else $error("sub overflow wrong");
   chk_mul_ovf: assert property (
      go && req.op == sfl_pkg::SFL_OP_MUL |=> w[2] == $past(e_mul))
      else $error("mul ovf");
   chk_div_ovf: assert property (
      go && req.op == sfl_pkg::SFL_OP_DIV |=> w[2] == $past(e_div))
      else $error("div overflow wrong");
   chk_parity_live: assert property (
      w[0] == ^acc && parity_flag == ^acc) else $error("parity wrong");
   chk_carry_zero: assert property (
      go && req.op inside {sfl_pkg::SFL_OP_MUL, sfl_pkg::SFL_OP_DIV,
      sfl_pkg::SFL_OP_CLR_C} |=> !w[7]) else $error("carry not cleared");
   chk_carry_one: assert property (
      go && req.op == sfl_pkg::SFL_OP_SETB_C |=> w[7]) else $error("carry set");
   chk_carry_arith: assert property (
      ad || sb |=> w[7] == $past(e_carry)) else $error("arith carry wrong");
   chk_aux_nibble: assert property (
      ad || sb |=> w[6] == $past(x4)) else $error("aux carry wrong");
   chk_cmp_carry: assert property (
      go && req.op == sfl_pkg::SFL_OP_CJNE |=> w[7] == $past(e_cmp))
      else $error("compare carry wrong");
   chk_flags_hold: assert property (
      !(go && req.op inside {[sfl_pkg::SFL_OP_ADD:sfl_pkg::SFL_OP_DIV]}) &&
      !(psel && penable && pwrite) |=> $stable(w[6:1])) else $error("flag moved");
   chk_gen_flags: assert property (
      (power_control & ~sfl_pkg::POWER_MASK) == 8'h00) else $error("gen bits");
endmodule
bind sfl_status_flags sfl_flag_checker u_chk (.pclk, .presetn, .clk_en, .psel,
   .penable, .pwrite, .req, .acc, .program_status_word, .power_control,
   .parity_flag);

/* verification/test_status_flag_logic.sv */
// Self-checking bench for the status flag logic
`timescale 1ns/1ps
module test_status_flag_logic;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              clk_en = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [11:0]       paddr = 12'h000;
   logic [31:0]       pwdata = 32'h00000000;
   logic [3:0]        pstrb = 4'h1;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   sfl_pkg::sfl_req_t req = '0;
   logic [7:0]        acc = 8'h00;
   logic [7:0]        program_status_word;
   logic [7:0]        power_control;
   logic              parity_flag;
   logic [31:0]       seed = 32'h3cc3bc3a;
   logic [7:1]        m = 7'h00;
   int                failures = 0;
   int                num_checks = 0;
   always #25 pclk = ~pclk;
   sfl_status_flags u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .req, .acc,
      .program_status_word, .power_control, .parity_flag);
   function automatic logic [31:0] xs;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // New {carry, overflow, aux} from old flags o
   function automatic logic [2:0] calc(input int k, input logic [7:0] a, b,
                                       input logic bi, da, input logic [2:0] o);
      logic [8:0] s;
      logic       c;
      s = (k == 3) ? a - b - o[2] : a + b + (k == 2 && o[2]);
      c = o[2];
      case (k)
         1, 2, 3: return {s[8], s[8] ^ s[7] ^ a[7] ^ b[7], s[4] ^ a[4] ^ b[4]};
         4: return {1'b0, a * b > 255, o[0]};
         5: return {1'b0, b == 8'h00, o[0]};
         6: c = o[2] | da;
         7: c = a[0];
         8: c = a[7];
         9: c = 1'b1;
         10: c = 1'b0;
         11: c = ~o[2];
         12: c = o[2] & bi;
         13: c = o[2] & ~bi;
         14: c = o[2] | bi;
         15: c = o[2] | ~bi;
         16: c = bi;
         17: c = a < b;
         default: c = o[2];
      endcase
      return {c, o[1:0]};
   endfunction
   task automatic chk(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic op(input int k, input logic [7:0] a, b);
      logic [31:0] n;
      n = xs();
      @(posedge pclk);
      req <= sfl_pkg::sfl_req_t'({1'b1, 5'(k), a, b, n[1:0]});
      acc <= n[15:8];
      if (clk_en)
         {m[7], m[2], m[6]} = calc(k, a, b, n[1], n[0], {m[7], m[2], m[6]});
      @(posedge pclk);
      req.valid <= 1'b0;
      @(negedge pclk);
      chk(program_status_word, {m, ^acc});
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, exp, input logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Values seen here are those standing at the access edge
      do @(posedge pclk); while (pready !== 1'b1);
      if (!wr) chk(prdata[7:0], exp);
      if (!wr) chk({7'h00, |prdata[31:8]}, 8'h00);
      chk({7'h00, pslverr}, {7'h00, err});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      report_and_stop();
   end
   initial begin
      logic [31:0] r;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, sfl_pkg::ADDR_STATUS, 8'h00, 8'h00, 1'b0);
      op(1, 8'h7f, 8'h01);
      op(2, 8'h80, 8'h80);
      op(3, 8'h80, 8'h01);
      op(3, 8'h00, 8'h01);
      op(3, 8'h10, 8'h01);
      op(4, 8'h10, 8'h10);
      op(4, 8'h0f, 8'h11);
      op(5, 8'h20, 8'h00);
      op(5, 8'h20, 8'h03);
      op(17, 8'h03, 8'h04);
      op(17, 8'h04, 8'h04);
      for (int k = 0; k < 18; k++) op(k, 8'h81, 8'h7e);
      for (int i = 0; i < 300; i++) begin
         r = xs();
         op(r[7:0] % 18, r[15:8], r[23:16]);
      end
      $display("flag update tests done");
      @(posedge pclk) clk_en <= 1'b0;
      op(1, 8'hff, 8'hff);
      @(posedge pclk) clk_en <= 1'b1;
      apb(1'b1, sfl_pkg::ADDR_STATUS, 8'hff, 8'h00, 1'b0);
      m = 7'h7f;
      apb(1'b0, sfl_pkg::ADDR_STATUS, 8'h00, {m, ^acc}, 1'b0);
      apb(1'b1, sfl_pkg::ADDR_STATUS, 8'h02, 8'h00, 1'b0);
      m = 7'h01;
      op(9, 8'h00, 8'h00);
      apb(1'b1, sfl_pkg::ADDR_POWER, 8'hff, 8'h00, 1'b0);
      apb(1'b0, sfl_pkg::ADDR_POWER, 8'h00, 8'h0c, 1'b0);
      @(posedge pclk) pstrb <= 4'h0;
      apb(1'b1, sfl_pkg::ADDR_POWER, 8'h00, 8'h00, 1'b0);
      @(negedge pclk);
      chk(power_control, 8'h0c);
      @(posedge pclk) pstrb <= 4'h1;
      apb(1'b1, sfl_pkg::ADDR_POWER, 8'h04, 8'h00, 1'b0);
      @(negedge pclk);
      chk(power_control, 8'h04);
      apb(1'b1, 12'h0fc, 8'hff, 8'h00, 1'b1);
      apb(1'b0, 12'h0fc, 8'h00, 8'h00, 1'b1);
      $display("register tests done");
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      m = 7'h00;
      apb(1'b0, sfl_pkg::ADDR_STATUS, 8'h00, {m, ^acc}, 1'b0);
      apb(1'b0, sfl_pkg::ADDR_POWER, 8'h00, 8'h00, 1'b0);
      $display("reset tests done");
      report_and_stop();
   end
endmodule
